// *** design/timer_cfg.svh ***
// Purpose: Offsets, field positions, reset values and divider taps of the compare timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TMR_OFF_CTRL 12'h000
`define TMR_OFF_STAT 12'h004
`define TMR_OFF_CONST_A 12'h008
`define TMR_OFF_CONST_B 12'h00c
`define TMR_OFF_COUNT 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMR_CTRL_IEN_B 7
`define TMR_CTRL_IEN_A 6
`define TMR_CTRL_IEN_W 5
`define TMR_STAT_FLAG_B 7
`define TMR_STAT_FLAG_A 6
`define TMR_STAT_FLAG_W 5
`define TMR_STAT_FIXED 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMR_RST_CTRL 8'h00
`define TMR_RST_STAT 8'h10
`define TMR_RST_CONST 8'hff
`define TMR_RST_COUNT 8'h00

// ----------------------------------------
// Prescaler taps: bit n toggles every 2**n cycles, period 2**(n+1)
// ----------------------------------------
`define TMR_DIV_W 10
`define TMR_TAP_DIV8 2
`define TMR_TAP_DIV64 5
`define TMR_TAP_DIV1024 9

`endif

// *** design/timer_pkg.sv ***
// Purpose: Types shared by the compare timer
// Assumes: Nothing beyond the cfg header
// Notes: Encodings of selection fields follow the control and status register layouts
package timer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] src_sel_t;
  typedef logic [1:0] clr_sel_t;
  typedef logic [1:0] out_act_t;
  typedef enum logic [1:0] {IRQ_NONE, IRQ_A, IRQ_B, IRQ_WRAP} irq_src_t;
endpackage : timer_pkg

// *** design/eight_bit_compare_timer.sv ***
// Purpose: 8-bit up-counting compare timer with APB register access
// Assumes: pclk 125 MHz, external pins are asynchronous to pclk
// Notes: Zero-wait APB slave, pready rises in every access phase
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"

module eight_bit_compare_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic ext_count_input,
  input wire logic ext_reset_input,
  output logic timer_output_pin,
  output logic timer_output_oe,
  // Interrupt controller
  output logic match_irq_a,
  output logic match_irq_b,
  output logic wrap_irq,
  output timer_pkg::irq_src_t irq_top,
  // Transfer controller
  output logic xfer_req_a,
  output logic xfer_req_b,
  input wire logic xfer_ack_a,
  input wire logic xfer_ack_b
);
  import timer_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address decode, used for both read and write paths
  function automatic logic [2:0] reg_index(input logic [11:0] addr);
    case (addr)
      `TMR_OFF_CTRL: reg_index = 3'h1;
      `TMR_OFF_STAT: reg_index = 3'h2;
      `TMR_OFF_CONST_A: reg_index = 3'h3;
      `TMR_OFF_CONST_B: reg_index = 3'h4;
      `TMR_OFF_COUNT: reg_index = 3'h5;
      default: reg_index = 3'h0;
    endcase
  endfunction : reg_index

  // Action of one channel when its event fires, else hold
  function automatic out_act_t chan_action(input out_act_t sel, input logic ev);
    chan_action = ev ? sel : 2'h0;
  endfunction : chan_action

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  byte_t ctrl_reg, const_a_reg, const_b_reg, timer_count_reg, timer_count_next;
  logic [3:0] os_reg;
  logic [2:0] arm_reg;
  logic [31:0] prdata_reg;
  logic [`TMR_DIV_W-1:0] div_reg;
  logic match_flag_a, match_flag_b, wrap_flag, pready_reg, pslverr_reg, out_reg, oe_reg;
  logic irq_a_reg, irq_b_reg, irq_w_reg, int_prev_reg, ext_prev_reg, rst_prev_reg;
  irq_src_t irq_top_reg;

  src_sel_t src_sel;
  clr_sel_t clr_sel;
  assign src_sel = ctrl_reg[2:0];
  assign clr_sel = ctrl_reg[4:3];

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  logic [2:0] acc_idx;
  logic acc_done, wr_ctrl, wr_stat, wr_const_a, wr_const_b, wr_cnt, rd_stat;

  assign acc_done = psel & penable & pready_reg;
  assign acc_idx = reg_index(paddr);
  assign wr_ctrl = acc_done & pwrite & (acc_idx == 3'h1);
  assign wr_stat = acc_done & pwrite & (acc_idx == 3'h2);
  assign wr_const_a = acc_done & pwrite & (acc_idx == 3'h3);
  assign wr_const_b = acc_done & pwrite & (acc_idx == 3'h4);
  assign wr_cnt = acc_done & pwrite & (acc_idx == 3'h5);
  assign rd_stat = acc_done & ~pwrite & (acc_idx == 3'h2);

  byte_t stat_view;
  assign stat_view = {match_flag_b, match_flag_a, wrap_flag, 1'b1, os_reg};

  // Answer is prepared in setup, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr_reg <= (reg_index(paddr) == 3'h0);
        case (reg_index(paddr))
          3'h1: prdata_reg <= {24'h00_0000, ctrl_reg};
          3'h2: prdata_reg <= {24'h00_0000, stat_view};
          3'h3: prdata_reg <= {24'h00_0000, const_a_reg};
          3'h4: prdata_reg <= {24'h00_0000, const_b_reg};
          3'h5: prdata_reg <= {24'h00_0000, timer_count_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TMR_RST_CTRL;
      os_reg <= 4'h0;
      const_a_reg <= `TMR_RST_CONST;
      const_b_reg <= `TMR_RST_CONST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (wr_stat) begin
        os_reg <= pwdata[3:0];
      end
      if (wr_const_a) begin
        const_a_reg <= pwdata[7:0];
      end
      if (wr_const_b) begin
        const_b_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Two flops only; pulses narrower than the documented minimum are lost
  logic [1:0] pin_raw, sync1_reg, sync2_reg;
  assign pin_raw = {ext_reset_input, ext_count_input};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Count source
  // ----------------------------------------
  logic int_lvl, ext_lvl, rst_lvl, inc;

  assign ext_lvl = sync2_reg[0];
  assign rst_lvl = sync2_reg[1];

  always_comb begin
    case (src_sel)
      3'h1: int_lvl = div_reg[`TMR_TAP_DIV8];
      3'h2: int_lvl = div_reg[`TMR_TAP_DIV64];
      3'h3: int_lvl = div_reg[`TMR_TAP_DIV1024];
      default: int_lvl = 1'b0;
    endcase
  end

  // Stopped and external selections read as low, so a change of selection
  // from a high tap to anything low is seen as a falling edge
  always_comb begin
    inc = int_prev_reg & ~int_lvl;
    case (src_sel)
      3'h5: inc = inc | (ext_lvl & ~ext_prev_reg);
      3'h6: inc = inc | (~ext_lvl & ext_prev_reg);
      3'h7: inc = inc | (ext_lvl ^ ext_prev_reg);
      default: inc = inc;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
      int_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      int_prev_reg <= int_lvl;
      ext_prev_reg <= ext_lvl;
      rst_prev_reg <= rst_lvl;
    end
  end

  // ----------------------------------------
  // Counter and compare
  // ----------------------------------------
  logic cmp_a, cmp_b, ext_clr, clr, wrap_set;

  assign cmp_a = inc & (timer_count_reg == const_a_reg) & ~wr_const_a;
  assign cmp_b = inc & (timer_count_reg == const_b_reg) & ~wr_const_b;
  assign ext_clr = (clr_sel == 2'h3) & rst_lvl & ~rst_prev_reg;
  assign clr = ext_clr | ((clr_sel == 2'h1) & cmp_a) | ((clr_sel == 2'h2) & cmp_b);
  assign wrap_set = inc & ~clr & ~wr_cnt & (timer_count_reg == 8'hff);

  always_comb begin
    if (clr) begin
      timer_count_next = 8'h00;
    end else if (wr_cnt) begin
      timer_count_next = pwdata[7:0];
    end else if (inc) begin
      timer_count_next = timer_count_reg + 8'h01;
    end else begin
      timer_count_next = timer_count_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= `TMR_RST_COUNT;
    end else begin
      timer_count_reg <= timer_count_next;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // A zero write clears a flag only after it was read as one; set wins
  logic [2:0] clr_req;
  assign clr_req[2] = (wr_stat & ~pwdata[`TMR_STAT_FLAG_B] & arm_reg[2]) | xfer_ack_b;
  assign clr_req[1] = (wr_stat & ~pwdata[`TMR_STAT_FLAG_A] & arm_reg[1]) | xfer_ack_a;
  assign clr_req[0] = wr_stat & ~pwdata[`TMR_STAT_FLAG_W] & arm_reg[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
      wrap_flag <= 1'b0;
      arm_reg <= 3'h0;
    end else begin
      match_flag_b <= cmp_b | (match_flag_b & ~clr_req[2]);
      match_flag_a <= cmp_a | (match_flag_a & ~clr_req[1]);
      wrap_flag <= wrap_set | (wrap_flag & ~clr_req[0]);
      if (rd_stat) begin
        arm_reg <= arm_reg | prdata_reg[`TMR_STAT_FLAG_B:`TMR_STAT_FLAG_W]; // Flags the read returned
      end else if (wr_stat) begin
        arm_reg <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // Timer output
  // ----------------------------------------
  out_act_t act_a, act_b;
  logic out_next;
  assign act_a = chan_action(os_reg[1:0], cmp_a);
  assign act_b = chan_action(os_reg[3:2], cmp_b);

  always_comb begin
    if (act_a == 2'h3 || act_b == 2'h3) begin
      out_next = ~out_reg;
    end else if (act_a == 2'h2 || act_b == 2'h2) begin
      out_next = 1'b1;
    end else if (act_a == 2'h1 || act_b == 2'h1) begin
      out_next = 1'b0;
    end else begin
      out_next = out_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= (os_reg != 4'h0);
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  logic ia, ib, iw;
  assign ia = match_flag_a & ctrl_reg[`TMR_CTRL_IEN_A];
  assign ib = match_flag_b & ctrl_reg[`TMR_CTRL_IEN_B];
  assign iw = wrap_flag & ctrl_reg[`TMR_CTRL_IEN_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      irq_w_reg <= 1'b0;
      irq_top_reg <= IRQ_NONE;
    end else begin
      irq_a_reg <= ia;
      irq_b_reg <= ib;
      irq_w_reg <= iw;
      if (ia) begin
        irq_top_reg <= IRQ_A;
      end else if (ib) begin
        irq_top_reg <= IRQ_B;
      end else if (iw) begin
        irq_top_reg <= IRQ_WRAP;
      end else begin
        irq_top_reg <= IRQ_NONE;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_output_pin = out_reg;
  assign timer_output_oe = oe_reg;
  assign match_irq_a = irq_a_reg;
  assign match_irq_b = irq_b_reg;
  assign wrap_irq = irq_w_reg;
  assign irq_top = irq_top_reg;
  // Wrap requests never reach the transfer controller
  assign xfer_req_a = irq_a_reg;
  assign xfer_req_b = irq_b_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_inc_advances: assert property (inc && !clr && !wr_cnt |=>
    timer_count_reg == $past(timer_count_reg) + 8'h01) else $error("count did not advance");
  a_match_sets_flag: assert property (cmp_a |=> match_flag_a)
    else $error("flag A not set after match");
  a_match_needs_pulse: assert property ($rose(match_flag_b) |-> $past(cmp_b))
    else $error("flag B rose without compare pulse");
  a_clear_on_a: assert property (cmp_a && clr_sel == 2'h1 |=> timer_count_reg == 8'h00)
    else $error("count not cleared on match A");
  a_wrap_sets: assert property (wrap_set |=> wrap_flag)
    else $error("wrap flag not set");
  a_irq_follows: assert property (match_flag_a && ctrl_reg[`TMR_CTRL_IEN_A] |=> match_irq_a)
    else $error("match A request missing");
  a_clear_beats_write: assert property (clr && wr_cnt |=> timer_count_reg == 8'h00)
    else $error("write beat the clear");
  a_write_beats_inc: assert property (wr_cnt && inc && !clr |=>
    timer_count_reg == $past(pwdata[7:0])) else $error("increment beat the write");
  a_const_write_mutes: assert property (wr_const_a && !match_flag_a |=> !match_flag_a)
    else $error("compare pulse during constant write");
  a_toggle_wins: assert property (cmp_a && cmp_b && act_a == 2'h3 |=>
    timer_output_pin != $past(timer_output_pin)) else $error("toggle lost its priority");
  a_fall_counts: assert property (int_prev_reg && !int_lvl && !clr && !wr_cnt |=>
    timer_count_reg == $past(timer_count_reg) + 8'h01) else $error("falling edge gave no count");
  a_oe_off: assert property (os_reg == 4'h0 |=> !timer_output_oe)
    else $error("output driven with no action selected");

  c_match_clear: cover property (cmp_a ##1 timer_count_reg == 8'h00);
  c_wrap: cover property (wrap_set ##1 wrap_irq);
  c_both_match: cover property (cmp_a && cmp_b);
  c_xfer_clear: cover property (match_flag_a && xfer_ack_a ##1 !match_flag_a);

endmodule : eight_bit_compare_timer
`default_nettype wire

// *** tb/xfer_ctrl_model.sv ***
// Purpose: Transfer controller model that serves the two match requests
// Assumes: Requests are levels that drop a few cycles after the acknowledge
// Notes: DELAY cycles pass before each acknowledge, so it can answer slowly
`timescale 1ns/100ps
`default_nettype none

module xfer_ctrl_model #(
  parameter int DELAY = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Service enable from the bench
  input wire logic en,
  // Request and acknowledge pairs
  input wire logic req_a,
  input wire logic req_b,
  output logic ack_a,
  output logic ack_b
);
  int cnt;
  logic busy;
  logic sel_a;

  // --------------------------------
  // Serve A before B; wrap is never served
  // --------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_a <= 1'b0;
      ack_b <= 1'b0;
      busy <= 1'b0;
      sel_a <= 1'b0;
      cnt <= 0;
    end else begin
      ack_a <= 1'b0;
      ack_b <= 1'b0;
      // Wait for the served request to drop, or it would be served twice
      if (busy) begin
        if (sel_a ? !req_a : !req_b) begin
          busy <= 1'b0;
        end
      end else if (en && (req_a || req_b)) begin
        if (cnt == DELAY) begin
          ack_a <= req_a;
          ack_b <= !req_a && req_b;
          sel_a <= req_a;
          busy <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule : xfer_ctrl_model

`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the compare timer over APB
// Assumes: Zero-wait APB slave; external pins toggled slowly
// Notes: Only ext-edge sources give exact counts; internal divider checked by range
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"

module tb_top;
  import timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_count_input = 1'b0;
  logic ext_reset_input = 1'b0;
  logic timer_output_pin;
  logic timer_output_oe;
  logic match_irq_a;
  logic match_irq_b;
  logic wrap_irq;
  irq_src_t irq_top;
  logic xfer_req_a;
  logic xfer_req_b;
  logic xfer_ack_a;
  logic xfer_ack_b;
  logic xfer_en = 1'b0;
  int errors = 0;
  int n_checks = 0;

  always #4 pclk = ~pclk;

  eight_bit_compare_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_input(ext_count_input),
    .ext_reset_input(ext_reset_input), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
    .wrap_irq(wrap_irq), .irq_top(irq_top), .xfer_req_a(xfer_req_a),
    .xfer_req_b(xfer_req_b), .xfer_ack_a(xfer_ack_a), .xfer_ack_b(xfer_ack_b));

  xfer_ctrl_model #(.DELAY(3)) partner (.pclk(pclk), .presetn(presetn), .en(xfer_en),
    .req_a(xfer_req_a), .req_b(xfer_req_b), .ack_a(xfer_ack_a), .ack_b(xfer_ack_b));

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task test_done;
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Entered just after a rising edge; one idle edge follows so psel is never set twice
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait whose answer never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd_chk

  // Levels held 4 cycles, well above the minimum pulse width
  task ext_pulse(input int n);
    repeat (n) begin
      ext_count_input <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_input <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask : ext_pulse

  // --------------------------------
  // Watchdog
  // --------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done();
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int lo;
    int hi;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`TMR_OFF_CTRL, 32'h0);
    rd_chk(`TMR_OFF_STAT, 32'h10);
    rd_chk(`TMR_OFF_CONST_A, 32'hff);
    rd_chk(`TMR_OFF_CONST_B, 32'hff);
    rd_chk(`TMR_OFF_COUNT, 32'h0);
    check({31'h0, timer_output_oe}, 32'h0);
    xfer(1'b0, 12'h014, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    // Every external code, stop included; count rewritten after each switch
    for (int s = 4; s < 8; s++) begin
      wr(`TMR_OFF_CTRL, s[7:0]);
      wr(`TMR_OFF_COUNT, 8'h00);
      ext_pulse(2);
      rd_chk(`TMR_OFF_COUNT, (s == 4) ? 32'h0 : (s == 7) ? 32'h4 : 32'h2);
    end
    // Pulse train: high on A, low on B, clear on A, irq A enabled
    wr(`TMR_OFF_CONST_A, 8'h03);
    wr(`TMR_OFF_CONST_B, 8'h01);
    wr(`TMR_OFF_STAT, 8'h06);
    wr(`TMR_OFF_CTRL, 8'h4d);
    wr(`TMR_OFF_COUNT, 8'h00);
    check({31'h0, timer_output_pin}, 32'h0);
    check({31'h0, timer_output_oe}, 32'h1);
    ext_pulse(3);
    rd_chk(`TMR_OFF_COUNT, 32'h3);
    rd_chk(`TMR_OFF_STAT, 32'h96);
    check({31'h0, timer_output_pin}, 32'h0);
    ext_pulse(1);
    rd_chk(`TMR_OFF_COUNT, 32'h0);
    rd_chk(`TMR_OFF_STAT, 32'hd6);
    check({31'h0, timer_output_pin}, 32'h1);
    check({31'h0, match_irq_a}, 32'h1);
    check({31'h0, match_irq_b}, 32'h0);
    check({30'h0, irq_top}, {30'h0, IRQ_A});
    check({31'h0, xfer_req_a}, 32'h1);
    check({31'h0, xfer_req_b}, 32'h0);
    ext_pulse(2);
    check({31'h0, timer_output_pin}, 32'h0);
    // Transfer controller serves A and the flag drops
    xfer_en <= 1'b1;
    repeat (12) @(posedge pclk);
    rd_chk(`TMR_OFF_STAT, 32'h96);
    check({31'h0, match_irq_a}, 32'h0);
    // Both matches at once: toggle on B beats low on A
    wr(`TMR_OFF_CONST_A, 8'h02);
    wr(`TMR_OFF_CONST_B, 8'h02);
    wr(`TMR_OFF_STAT, 8'h0d);
    wr(`TMR_OFF_CTRL, 8'h05);
    wr(`TMR_OFF_COUNT, 8'h00);
    ext_pulse(3);
    check({31'h0, timer_output_pin}, 32'h1);
    wr(`TMR_OFF_STAT, 8'h00);
    repeat (2) @(posedge pclk);
    check({31'h0, timer_output_oe}, 32'h0);
    // Wrap with its interrupt enabled, then masked, then cleared
    wr(`TMR_OFF_CTRL, 8'h25);
    wr(`TMR_OFF_COUNT, 8'hff);
    ext_pulse(1);
    rd_chk(`TMR_OFF_COUNT, 32'h0);
    xfer(1'b0, `TMR_OFF_STAT, 32'h0, r, e);
    check(r & 32'h20, 32'h20);
    check({31'h0, wrap_irq}, 32'h1);
    check({30'h0, irq_top}, {30'h0, IRQ_WRAP});
    wr(`TMR_OFF_CTRL, 8'h05);
    repeat (2) @(posedge pclk);
    check({31'h0, wrap_irq}, 32'h0);
    wr(`TMR_OFF_STAT, 8'h00);
    rd_chk(`TMR_OFF_STAT, 32'h10);
    // External reset clears the count
    wr(`TMR_OFF_CTRL, 8'h1d);
    wr(`TMR_OFF_COUNT, 8'h40);
    ext_reset_input <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_reset_input <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(`TMR_OFF_COUNT, 32'h0);
    // Internal taps /8, /64, /1024: phase unknown and stopping may add one, so a range
    for (int s = 1; s < 4; s++) begin
      lo = (s == 1) ? 9 : (s == 2) ? 3 : 1;
      hi = (s == 1) ? 12 : (s == 2) ? 5 : 3;
      wr(`TMR_OFF_CTRL, s[7:0]);
      wr(`TMR_OFF_COUNT, 8'h00);
      repeat ((s == 1) ? 80 : (s == 2) ? 200 : 1100) @(posedge pclk);
      wr(`TMR_OFF_CTRL, 8'h00);
      xfer(1'b0, `TMR_OFF_COUNT, 32'h0, r, e);
      check({31'h0, (r >= lo && r <= hi)}, 32'h1);
    end
    test_done();
  end
endmodule : tb_top

`default_nettype wire
